// ==== rtl/lpc_pkg.sv ====
package lpc_pkg;

   // ****************************************************************
   // Wishbone register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] LPC_ADR_FUNC   = 8'h00;
   localparam logic [7:0] LPC_ADR_STATUS = 8'h04;
   localparam logic [7:0] LPC_ADR_DATA   = 8'h08;
   localparam logic [7:0] LPC_ADR_MOTION = 8'h0c;
   localparam logic [7:0] LPC_ADR_IMGADR = 8'h10;
   localparam logic [7:0] LPC_ADR_IMGDAT = 8'h14;
   localparam logic [7:0] LPC_ADR_LINE   = 8'h18;

   // ****************************************************************
   // Function register bits
   // ****************************************************************
   localparam int LPC_FN_CLEAR     = 0;
   localparam int LPC_FN_CLR_INT   = 1;
   localparam int LPC_FN_DATA_REQ  = 2;
   localparam int LPC_FN_END_REQ   = 3;
   localparam int LPC_FN_ALARM_REQ = 4;
   localparam int LPC_FN_PRINT     = 5;
   localparam int LPC_FN_CLR_DATA  = 6;
   localparam int LPC_FN_CLR_END   = 7;
   localparam int LPC_FN_CLR_ALARM = 8;
   localparam int LPC_FN_EIGHT_LPI = 9;
   localparam int LPC_FN_SIX_LPI   = 10;

   // ****************************************************************
   // Status word bits
   // ****************************************************************
   localparam int LPC_ST_READY    = 0;
   localparam int LPC_ST_BUSY     = 1;
   localparam int LPC_ST_INT      = 2;
   localparam int LPC_ST_DATA     = 3;
   localparam int LPC_ST_END      = 4;
   localparam int LPC_ST_ALARM    = 5;
   localparam int LPC_ST_ABNORMAL = 6;
   localparam int LPC_ST_EIGHT    = 9;

   // ****************************************************************
   // Paper motion codes written to the motion register
   // ****************************************************************
   localparam logic [3:0] LPC_MV_SINGLE   = 4'h1;
   localparam logic [3:0] LPC_MV_DOUBLE   = 4'h2;
   localparam logic [3:0] LPC_MV_SUPPRESS = 4'h3;
   localparam logic [3:0] LPC_MV_TOP      = 4'h4;
   localparam logic [3:0] LPC_MV_LAST     = 4'h5;
   localparam logic [3:0] LPC_MV_EJECT    = 4'h6;
   localparam logic [3:0] LPC_MV_LEVEL    = 4'h7;

   // ****************************************************************
   // Sizes and timing
   // ****************************************************************
   localparam int LPC_IMAGE_LOCS  = 288;
   localparam int LPC_LINE_WORDS  = 68;
   localparam int LPC_FORM_LINES  = 66;
   localparam int LPC_LEVELS      = 12;
   localparam int LPC_LAST_LEVEL  = 11;
   localparam int LPC_CLK_HZ      = 25000000;
   localparam int LPC_BUSY_MAX_MS = 750;
   localparam int LPC_PRINT_MS    = 100;
   localparam int LPC_LINE_MS     = 10;
   localparam int LPC_PRINT_CYC   = LPC_CLK_HZ / 1000 * LPC_PRINT_MS;
   localparam int LPC_LINE_CYC    = LPC_CLK_HZ / 1000 * LPC_LINE_MS;
   localparam int LPC_BUSY_MAX_CYC = LPC_CLK_HZ / 1000 * LPC_BUSY_MAX_MS;

   // ****************************************************************
   // Mechanism states
   // ****************************************************************
   typedef enum logic [1:0] {
      LPC_IDLE,
      LPC_ADVANCE,
      LPC_STRIKE
   } lpc_mech_type;

endpackage

// ==== rtl/lpc_top.sv ====
`timescale 1ns/1ps
module lpc_top
   import lpc_pkg::*;
#(
   parameter int PRINT_CYC    = LPC_PRINT_CYC,
   parameter int LINE_CYC     = LPC_LINE_CYC,
   parameter int BUSY_MAX_CYC = LPC_BUSY_MAX_CYC,
   parameter int LINE_WORDS   = LPC_LINE_WORDS
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   output logic             irq_o,
   output logic             strike_o,
   output logic      [6:0]  strike_line_o,
   output logic      [6:0]  strike_len_o,
   output logic             paper_step_o
);

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   initial begin
      if (PRINT_CYC < 1 || LINE_CYC < 1 || PRINT_CYC + 4 * LINE_CYC > BUSY_MAX_CYC) begin
         $error("lpc_top: timing parameters cannot keep busy short enough");
      end
      if (LINE_WORDS < 1 || LINE_WORDS > 127) begin
         $error("lpc_top: line length out of range");
      end
   end

   // ****************************************************************
   // Memories and format tape
   // ****************************************************************
   logic [7:0]  image_mem [LPC_IMAGE_LOCS];
   logic [15:0] line_mem  [LINE_WORDS];
   logic [11:0] tape_rom  [LPC_FORM_LINES];

   // Tape has level 1 on the first frame, level 12 on the last line of form.
   always_comb begin
      for (int f = 0; f < LPC_FORM_LINES; f++) begin
         tape_rom[f] = 12'h000;
         tape_rom[f][(f % LPC_LEVELS)] = 1'b1;
      end
      tape_rom[LPC_FORM_LINES - 1][LPC_LAST_LEVEL] = 1'b1;
   end

   // ****************************************************************
   // State record
   // ****************************************************************
   typedef struct packed {
      logic [31:0]  dat;
      logic         ack;
      logic         err;
      logic         irq;
      logic         strike;
      logic [6:0]   strike_line;
      logic [6:0]   strike_len;
      logic         paper_step;
      lpc_mech_type mech;
      logic [31:0]  timer;
      logic [6:0]   line_pos;
      logic [6:0]   steps_left;
      logic [11:0]  seek_mask;
      logic         print_after;
      logic         suppress;
      logic         eight_lpi;
      logic         arm_data;
      logic         arm_end;
      logic         arm_alarm;
      logic         st_int;
      logic         st_data;
      logic         st_end;
      logic         st_alarm;
      logic         st_abnormal;
      logic [6:0]   load_cnt;
      logic [6:0]   line_len;
      logic [8:0]   img_adr;
      logic         was_motion;
   } lpc_state_type;

   lpc_state_type s_q;
   lpc_state_type s_d;

   logic access;
   logic wr_line;
   logic wr_img;

   // Bus request in its first cycle; the ack pulse keeps writes to one.
   assign access  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wr_line = access && wb_we_i && wb_adr_i == LPC_ADR_DATA
                    && s_q.load_cnt < 7'(LINE_WORDS);
   assign wr_img  = access && wb_we_i && wb_adr_i == LPC_ADR_IMGDAT
                    && s_q.img_adr < 9'(LPC_IMAGE_LOCS);

   // Count of line frames to reach the next frame punched in the levels.
   function automatic logic [6:0] lpc_seek(input logic [6:0] pos, input logic [11:0] lv);
      logic [6:0] n;
      logic       found;
      n = 7'd0;
      found = 1'b0;
      for (int k = 1; k <= LPC_FORM_LINES; k++) begin
         if (!found && (tape_rom[(int'(pos) + k) % LPC_FORM_LINES] & lv) != 12'h000) begin
            n = 7'(k);
            found = 1'b1;
         end
      end
      return found ? n : 7'd1;
   endfunction

   // Frames to the top (or the last line) of form; a whole form when already there.
   function automatic logic [6:0] lpc_dist(input logic [6:0] pos, input logic last);
      return 7'((int'(last) * (LPC_FORM_LINES - 1) + LPC_FORM_LINES - 1 - int'(pos))
                % LPC_FORM_LINES + 1);
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [11:0] fn;
      logic [31:0] adv_cyc;
      logic        done;
      s_d = s_q;
      fn = 12'h000;
      done = 1'b0;
      s_d.ack = 1'b0;
      s_d.err = 1'b0;
      s_d.strike = 1'b0;
      s_d.paper_step = 1'b0;
      adv_cyc = s_q.eight_lpi ? 32'(LINE_CYC * 3 / 4) : 32'(LINE_CYC);
      if (adv_cyc == 32'd0) begin
         adv_cyc = 32'd1;
      end

      // Register reads and writes; every mapped access is acknowledged.
      if (access) begin
         s_d.ack = 1'b1;
         s_d.dat = 32'h0;
         case (wb_adr_i)
            LPC_ADR_FUNC: begin
               if (wb_we_i) begin
                  fn = wb_dat_i[11:0];
               end
            end
            LPC_ADR_STATUS: begin
               s_d.dat[LPC_ST_READY]    = 1'b1;
               s_d.dat[LPC_ST_BUSY]     = s_q.mech != LPC_IDLE;
               s_d.dat[LPC_ST_INT]      = s_q.irq;
               s_d.dat[LPC_ST_DATA]     = s_q.st_data;
               s_d.dat[LPC_ST_END]      = s_q.st_end;
               s_d.dat[LPC_ST_ALARM]    = s_q.st_alarm;
               s_d.dat[LPC_ST_ABNORMAL] = s_q.st_abnormal;
               s_d.dat[LPC_ST_EIGHT]    = s_q.eight_lpi;
            end
            LPC_ADR_DATA: begin
               if (wb_we_i && s_q.load_cnt < 7'(LINE_WORDS)) begin
                  s_d.load_cnt = s_q.load_cnt + 7'd1;
               end
               s_d.dat[6:0] = s_q.load_cnt;
            end
            LPC_ADR_MOTION: begin
               if (wb_we_i && s_q.mech == LPC_IDLE) begin
                  s_d.was_motion = 1'b1;
                  s_d.print_after = 1'b0;
                  case (wb_dat_i[3:0])
                     LPC_MV_SINGLE:   s_d.steps_left = 7'd1;
                     LPC_MV_DOUBLE:   s_d.steps_left = 7'd2;
                     LPC_MV_SUPPRESS: begin
                        s_d.suppress = 1'b1;
                        s_d.was_motion = 1'b0;
                     end
                     LPC_MV_TOP:      s_d.steps_left = lpc_dist(s_q.line_pos, 1'b0);
                     LPC_MV_LAST:     s_d.steps_left = lpc_dist(s_q.line_pos, 1'b1);
                     LPC_MV_EJECT:    s_d.steps_left = lpc_dist(s_q.line_pos, 1'b0);
                     LPC_MV_LEVEL: begin
                        s_d.seek_mask = 12'h001 << (wb_dat_i[7:4] - 4'd1);
                        s_d.was_motion = 1'b0;
                     end
                     default:         s_d.was_motion = 1'b0;
                  endcase
                  if (s_d.was_motion) begin
                     s_d.mech = LPC_ADVANCE;
                     s_d.timer = adv_cyc;
                  end
               end
               s_d.dat[11:0] = s_q.seek_mask;
            end
            LPC_ADR_IMGADR: begin
               if (wb_we_i) begin
                  s_d.img_adr = wb_dat_i[8:0];
               end
               s_d.dat[8:0] = s_q.img_adr;
            end
            LPC_ADR_IMGDAT: begin
               if (wb_we_i && s_q.img_adr < 9'(LPC_IMAGE_LOCS)) begin
                  s_d.img_adr = s_q.img_adr + 9'd1;
               end
               if (s_q.img_adr < 9'(LPC_IMAGE_LOCS)) begin
                  s_d.dat[7:0] = image_mem[s_q.img_adr];
               end
            end
            LPC_ADR_LINE: begin
               s_d.dat[6:0] = s_q.line_pos;
               s_d.dat[14:8] = s_q.line_len;
            end
            default: begin
               s_d.ack = 1'b0;
               s_d.err = 1'b1;
            end
         endcase
      end

      // Clears and arming; a later arm in the same word wins over a clear.
      if (fn[LPC_FN_CLEAR]) begin
         s_d.arm_data = 1'b0;
         s_d.arm_end = 1'b0;
         s_d.arm_alarm = 1'b0;
         s_d.load_cnt = 7'd0;
         s_d.suppress = 1'b0;
         s_d.mech = LPC_IDLE;
         s_d.print_after = 1'b0;
      end
      if (fn[LPC_FN_CLEAR] || fn[LPC_FN_CLR_INT]) begin
         s_d.st_int = 1'b0;
         s_d.st_data = 1'b0;
         s_d.st_end = 1'b0;
         s_d.st_alarm = 1'b0;
         s_d.st_abnormal = 1'b0;
      end
      if (fn[LPC_FN_CLR_DATA]) begin
         s_d.arm_data = 1'b0;
      end
      if (fn[LPC_FN_CLR_END]) begin
         s_d.arm_end = 1'b0;
      end
      if (fn[LPC_FN_CLR_ALARM]) begin
         s_d.arm_alarm = 1'b0;
      end
      if (fn[LPC_FN_DATA_REQ]) begin
         s_d.arm_data = 1'b1;
      end
      if (fn[LPC_FN_END_REQ]) begin
         s_d.arm_end = 1'b1;
      end
      if (fn[LPC_FN_ALARM_REQ]) begin
         s_d.arm_alarm = 1'b1;
      end
      if (fn[LPC_FN_EIGHT_LPI]) begin
         s_d.eight_lpi = 1'b1;
      end
      if (fn[LPC_FN_SIX_LPI]) begin
         s_d.eight_lpi = 1'b0;
      end
      if (fn[LPC_FN_PRINT] && s_q.mech == LPC_IDLE) begin
         s_d.was_motion = 1'b0;
         s_d.line_len = s_d.load_cnt;
         s_d.load_cnt = 7'd0;
         if (s_q.seek_mask != 12'h000) begin
            s_d.steps_left = lpc_seek(s_q.line_pos, s_q.seek_mask);
            s_d.seek_mask = 12'h000;
            s_d.print_after = 1'b1;
            s_d.mech = LPC_ADVANCE;
            s_d.timer = adv_cyc;
         end else begin
            s_d.mech = LPC_STRIKE;
            s_d.timer = 32'(PRINT_CYC);
            s_d.strike = 1'b1;
         end
      end

      // Mechanism: paper stepping and hammer strike, each timed.
      case (s_q.mech)
         LPC_IDLE: begin
         end
         LPC_ADVANCE: begin
            s_d.timer = s_q.timer - 32'd1;
            if (s_q.timer == 32'd1) begin
               s_d.paper_step = 1'b1;
               s_d.line_pos = (s_q.line_pos == 7'(LPC_FORM_LINES - 1)) ? 7'd0
                              : s_q.line_pos + 7'd1;
               s_d.steps_left = s_q.steps_left - 7'd1;
               if (s_q.steps_left > 7'd1) begin
                  s_d.timer = adv_cyc;
               end else if (s_q.print_after) begin
                  s_d.mech = LPC_STRIKE;
                  s_d.print_after = 1'b0;
                  s_d.timer = 32'(PRINT_CYC);
                  s_d.strike = 1'b1;
               end else begin
                  s_d.mech = LPC_IDLE;
                  done = 1'b1;
               end
            end
         end
         LPC_STRIKE: begin
            s_d.timer = s_q.timer - 32'd1;
            if (s_q.timer == 32'd1) begin
               done = 1'b1;
               if (s_q.suppress) begin
                  s_d.suppress = 1'b0;
                  s_d.mech = LPC_IDLE;
               end else begin
                  s_d.steps_left = 7'd1;
                  s_d.mech = LPC_ADVANCE;
                  s_d.timer = adv_cyc;
               end
            end
         end
         default: s_d.mech = LPC_IDLE;
      endcase

      // Completion events: a set here wins over a clear in the same cycle.
      if (done) begin
         if (!s_q.was_motion && s_q.line_len == 7'd0) begin
            s_d.st_abnormal = 1'b1;
            if (s_q.arm_alarm) begin
               s_d.st_alarm = 1'b1;
               s_d.st_int = 1'b1;
            end
         end
         if (!s_q.was_motion && s_q.arm_data) begin
            s_d.st_data = 1'b1;
            s_d.st_int = 1'b1;
         end
         if (s_q.arm_end) begin
            s_d.st_end = 1'b1;
            s_d.st_data = 1'b1;
            s_d.st_int = 1'b1;
         end
      end
      s_d.irq = s_d.st_int;
      s_d.strike_line = s_d.line_pos;
      s_d.strike_len = s_d.line_len;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.mech <= LPC_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Memory writes from the bus.
   always_ff @(posedge clk_i) begin
      if (wr_line) begin
         line_mem[s_q.load_cnt] <= wb_dat_i[15:0];
      end
      if (wr_img) begin
         image_mem[s_q.img_adr] <= wb_dat_i[7:0];
      end
   end

   assign wb_dat_o      = s_q.dat;
   assign wb_ack_o      = s_q.ack;
   assign wb_err_o      = s_q.err;
   assign irq_o         = s_q.irq;
   assign strike_o      = s_q.strike;
   assign strike_line_o = s_q.strike_line;
   assign strike_len_o  = s_q.strike_len;
   assign paper_step_o  = s_q.paper_step;

endmodule

// ==== verification/lpc_properties.sv ====
`timescale 1ns/1ps
// ****************
// Port checker.
// ****************
module lpc_properties
   import lpc_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic        irq_o,
   input wire logic        strike_o,
   input wire logic [6:0]  strike_line_o,
   input wire logic [6:0]  strike_len_o,
   input wire logic        paper_step_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Decode of mapped words and of writes that may drop the interrupt.
   logic mapped;
   logic clr_wr;
   assign mapped = (wb_adr_i <= LPC_ADR_LINE) && (wb_adr_i[1:0] == 2'b00);
   assign clr_wr = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == LPC_ADR_FUNC)
                   && (wb_dat_i[LPC_FN_CLEAR] || wb_dat_i[LPC_FN_CLR_INT]);
   // A request taken, and a read of word a taken.
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_rd(a);
      s_taken ##0 (!wb_we_i && wb_adr_i == a);
   endsequence
   a_answer_next: assert property (s_taken |=> wb_ack_o ^ wb_err_o)
      else $error("no single answer after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_err_unmapped: assert property (s_taken ##0 !mapped |=> wb_err_o)
      else $error("unmapped access not refused");
   a_no_reject: assert property (s_taken ##0 mapped |=> wb_ack_o && !wb_err_o)
      else $error("mapped access refused");
   a_ready_read: assert property (s_rd(LPC_ADR_STATUS) |=> wb_dat_o[LPC_ST_READY])
      else $error("status read without ready");
   a_func_zero: assert property (s_rd(LPC_ADR_FUNC) |=> wb_dat_o == 32'h0)
      else $error("function word read not zero");
   a_irq_held: assert property ($fell(irq_o) |-> $past(clr_wr) || $past(clr_wr, 2))
      else $error("interrupt dropped without clear");
   a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !wb_ack_o && !strike_o)
      else $error("outputs active after reset");
   a_strike_gap: assert property (strike_o |=> !strike_o [*8])
      else $error("strikes too close");
   a_step_pulse: assert property (paper_step_o |=> !paper_step_o)
      else $error("paper step longer than one cycle");
endmodule
bind lpc_top lpc_properties lpc_properties_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_o(irq_o),
   .strike_o(strike_o), .strike_line_o(strike_line_o), .strike_len_o(strike_len_o),
   .paper_step_o(paper_step_o)
);

// ==== verification/lpc_host.sv ====
`timescale 1ns/1ps
// ****************
// Host bus master.
// ****************
module lpc_host (
   input  wire logic        clk_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i,
   input  wire logic        wb_err_i,
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic      [7:0]  wb_adr_o,
   output logic      [31:0] wb_dat_o
);
   // The bus is idle from time zero.
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_dat_o = 32'h0;
   end
   // One classic cycle, held until answered, then idle for a cycle.
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= a;
      wb_dat_o <= d;
      do begin
         @(posedge clk_i);
      end while (!(wb_ack_i || wb_err_i));
      q = wb_dat_i;
      e = wb_err_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import lpc_pkg::*;
   localparam int PCYC = 20;
   localparam int LCYC = 8;
   typedef struct packed {
      logic [10:0] arm;
      logic [10:0] clr;
      logic [7:0]  mv;
      logic        one;
      logic [4:0]  exp;
      logic [4:0]  msk;
      logic [6:0]  line;
   } lpc_row_type;
   logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, irq, strike, step;
   logic [7:0]  wb_adr;
   logic [31:0] wb_wdat, wb_rdat, q;
   logic [6:0]  s_line, s_len, last_line, last_len;
   logic        e, eo;
   int          n_fail, tests_run, i, cyc_n, t0, n_strike;
   // Status bits 6..2 after each row: abnormal, alarm, end, data, interrupt.
   lpc_row_type rows [12] = '{
      '{11'h010, 11'h000, 8'h00, 1'b0, 5'h19, 5'h1f, 7'h00},
      '{11'h010, 11'h100, 8'h00, 1'b0, 5'h00, 5'h09, 7'h00},
      '{11'h004, 11'h000, 8'h04, 1'b1, 5'h03, 5'h1f, 7'h00},
      '{11'h008, 11'h040, 8'h01, 1'b1, 5'h07, 5'h1f, 7'h02},
      '{11'h004, 11'h0c0, 8'h02, 1'b1, 5'h00, 5'h1f, 7'h05},
      '{11'h000, 11'h000, 8'h03, 1'b1, 5'h00, 5'h1f, 7'h06},
      '{11'h000, 11'h000, 8'h03, 1'b1, 5'h00, 5'h1f, 7'h06},
      '{11'h000, 11'h000, 8'h05, 1'b1, 5'h00, 5'h1f, 7'h41},
      '{11'h000, 11'h000, 8'h37, 1'b1, 5'h00, 5'h1f, 7'h02},
      '{11'h000, 11'h000, 8'h06, 1'b1, 5'h00, 5'h1f, 7'h00},
      '{11'h000, 11'h000, 8'hc7, 1'b1, 5'h00, 5'h1f, 7'h0b},
      '{11'h008, 11'h000, 8'h04, 1'b1, 5'h07, 5'h1f, 7'h00}};
   lpc_top #(.PRINT_CYC(PCYC), .LINE_CYC(LCYC)) lpc_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .wb_err_o(wb_err), .irq_o(irq),
      .strike_o(strike), .strike_line_o(s_line), .strike_len_o(s_len),
      .paper_step_o(step));
   lpc_host lpc_host_inst (
      .clk_i(clk_i), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack), .wb_err_i(wb_err),
      .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
      .wb_dat_o(wb_wdat));
   // ****************
   // Clock, cycle count and strike capture.
   // ****************
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (strike === 1'b1) begin
         last_line <= s_line;
         last_len <= s_len;
         n_strike <= n_strike + 1;
      end
   end
   // ****************
   // Tasks.
   // ****************
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      lpc_host_inst.xfer(1'b1, a, d, q, e);
   endtask
   task rd(input logic [7:0] a);
      lpc_host_inst.xfer(1'b0, a, 32'h0, q, e);
   endtask
   // Poll status until busy drops, with a bound on the polls.
   task idle;
      int n;
      n = 0;
      do begin
         rd(LPC_ADR_STATUS);
         n++;
      end while (q[LPC_ST_BUSY] !== 1'b0 && n < 400);
      chk("idle", 32'(n < 400), 32'h1);
   endtask
   task final_report;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog far beyond the expected few thousand cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      final_report;
   end
   // ****************
   // Main sequence.
   // ****************
   initial begin
      eo = 1'b0;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (i = 0; i < 12; i++) begin
         wr(LPC_ADR_FUNC, 32'h2);
         wr(LPC_ADR_FUNC, 32'(rows[i].arm));
         if (rows[i].clr != 11'h0) wr(LPC_ADR_FUNC, 32'(rows[i].clr));
         eo = (eo || rows[i].arm[3]) && !rows[i].clr[7];
         if (rows[i].mv != 8'h0) begin
            wr(LPC_ADR_MOTION, 32'(rows[i].mv));
            idle;
            if (rows[i].mv[3:0] != 4'h3 && rows[i].mv[3:0] != 4'h7) begin
               rd(LPC_ADR_STATUS);
               chk("motion end", 32'(q[LPC_ST_INT]), 32'(eo));
            end
            wr(LPC_ADR_FUNC, 32'h2);
         end
         t0 = n_strike;
         if (rows[i].one) wr(LPC_ADR_DATA, 32'h4142);
         wr(LPC_ADR_FUNC, 32'h20);
         idle;
         rd(LPC_ADR_STATUS);
         chk("status", 32'(q[6:2] & rows[i].msk), 32'(rows[i].exp & rows[i].msk));
         chk("irq", 32'(irq), 32'(rows[i].exp[0]));
         if (rows[i].one) chk("line", 32'(last_line), 32'(rows[i].line));
         chk("strikes", 32'(n_strike - t0), 32'h1);
         $display("row %0d done", i);
      end
      for (i = 0; i < 3; i++) begin
         wr(LPC_ADR_FUNC, 32'h1);
         rd(LPC_ADR_STATUS);
         chk("ready idle", 32'(q[1:0]), 32'h1);
      end
      $display("clear test done");
      for (i = 0; i < 69; i++) wr(LPC_ADR_DATA, 32'h3334);
      rd(LPC_ADR_DATA);
      chk("count", 32'(q[6:0]), 32'd68);
      wr(LPC_ADR_FUNC, 32'h24);
      t0 = cyc_n;
      rd(LPC_ADR_STATUS);
      chk("busy", 32'(q[LPC_ST_BUSY]), 32'h1);
      idle;
      chk("busy span", 32'(cyc_n - t0 <= PCYC + LCYC + 8), 32'h1);
      chk("length", 32'(last_len), 32'd68);
      repeat (20) @(posedge clk_i);
      chk("irq held", 32'(irq), 32'h1);
      wr(LPC_ADR_FUNC, 32'h2);
      chk("irq clear", 32'(irq), 32'h0);
      $display("busy test done");
      wr(LPC_ADR_FUNC, 32'h200);
      rd(LPC_ADR_STATUS);
      chk("eight lpi", 32'(q[LPC_ST_EIGHT]), 32'h1);
      wr(LPC_ADR_FUNC, 32'h400);
      rd(LPC_ADR_STATUS);
      chk("six lpi", 32'(q[LPC_ST_EIGHT]), 32'h0);
      rd(8'h1c);
      chk("unmapped", 32'(e), 32'h1);
      rd(LPC_ADR_LINE);
      chk("mapped", 32'(e), 32'h0);
      $display("spacing and bus test done");
      wr(LPC_ADR_IMGADR, 32'h11e);
      wr(LPC_ADR_IMGDAT, 32'hcc);
      wr(LPC_ADR_IMGDAT, 32'h33);
      wr(LPC_ADR_IMGDAT, 32'h55);
      wr(LPC_ADR_IMGADR, 32'h11f);
      rd(LPC_ADR_IMGDAT);
      chk("image last", q, 32'h33);
      wr(LPC_ADR_IMGADR, 32'h11e);
      wr(LPC_ADR_IMGDAT, 32'h5a);
      wr(LPC_ADR_IMGADR, 32'h11e);
      rd(LPC_ADR_IMGDAT);
      chk("image rewrite", q, 32'h5a);
      $display("image test done");
      wr(LPC_ADR_FUNC, 32'h200);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(LPC_ADR_STATUS);
      chk("after reset", q, 32'h1);
      $display("reset test done");
      final_report;
   end
endmodule
